// *** hdl/rotp_top.sv ***
// rotp_top: remote on/off, trigger, shutdown and flag control with APB registers
// assumes pins are asynchronous; shutdown clears only on presetn (power-on reset)
// Function
// - default polarity: low disables, high enables output
// - control bit inverts remote on/off sense
// - ignore mode: only on/off commands govern output
// - standby mode: 100us low disables, enters standby
// - standby: high does not restore; on command does
// - act on remote input change within 200ms
// - 100us low trigger input makes one event
// - no new trigger until input returns high
// - answer valid trigger within 500us
// - shutdown input stops function, removes output
// - shutdown completes within 100us
// - shutdown latched until power cycle only
// - power-ok flag conducts only when operating normally
// - output-off flag conducts while output is off
// - list trigger setup turns flag into trigger output
// - setup sets flag active state and pulse width
// - list clear restores flag to output state
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module rotp_top #(
    parameter int unsigned TRIG_RESP_MAX_CYC =
        rotp_pkg::TRIG_RESP_MAX_US * rotp_pkg::CLK_KHZ / 1000,
    parameter int unsigned REM_RESP_MAX_CYC  =
        rotp_pkg::REM_RESP_MAX_MS * rotp_pkg::CLK_KHZ
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // discrete inputs
    input  wire logic        remote_onoff_in,
    input  wire logic        ext_trigger_in,
    input  wire logic        ext_shutdown_in,
    // discrete outputs
    output logic             output_enable,
    output logic             trigger_event,
    output logic             power_ok_flag_on,
    output logic             output_off_flag_on,
    output logic             power_fault_red,
    output logic             irq
);
    typedef struct packed {
        logic                 pready;
        logic                 pslverr;
        logic [31:0]          prdata;
        logic                 inv;
        logic                 ign;
        logic                 stby;
        logic                 sw_on;
        logic                 standby;
        logic                 shdn;
        rotp_pkg::rotp_flag_t flag;
        logic                 act;
        logic [15:0]          width;
        logic [15:0]          pcnt;
        logic                 armed;
        logic                 trig_ev;
        logic                 rem_prev;
        logic [3:0]           ist;
        logic [3:0]           imask;
        logic                 irq;
        logic                 out_en;
        logic                 ok_flag;
        logic                 off_flag;
        logic                 red;
        logic [22:0]          rcnt;
        logic [13:0]          tcnt;
        logic [11:0]          scnt;
    } rotp_st_t;

    rotp_st_t s_r;
    rotp_st_t s_nxt;

    logic rem_sync;
    logic rem_q;
    logic trig_sync;
    logic trig_q;
    logic shd_sync;
    logic shd_q;

    // remote on/off: held 100us before use, well inside 200ms
    rotp_qual #(.N(rotp_pkg::QUAL_CYC), .INIT(1'b1)) u_rem (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     (remote_onoff_in),
        .sync    (rem_sync),
        .level   (rem_q)
    );

    // trigger input: a low shorter than 100us never fires
    rotp_qual #(.N(rotp_pkg::QUAL_CYC), .INIT(1'b1)) u_trig (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     (ext_trigger_in),
        .sync    (trig_sync),
        .level   (trig_q)
    );

    // shutdown: short filter only, the 100us budget leaves no room for more
    rotp_qual #(.N(rotp_pkg::SHDN_FILT_CYC), .INIT(1'b0)) u_shd (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     (ext_shutdown_in),
        .sync    (shd_sync),
        .level   (shd_q)
    );

    // address decode, shared by read and write paths
    function automatic logic is_reg(input logic [7:0] a, input logic [7:0] off);
        is_reg = (a == off);
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        mapped = is_reg(a, rotp_pkg::REG_CTRL)   || is_reg(a, rotp_pkg::REG_CMD) ||
                 is_reg(a, rotp_pkg::REG_TRIG)   || is_reg(a, rotp_pkg::REG_IST) ||
                 is_reg(a, rotp_pkg::REG_STATUS) || is_reg(a, rotp_pkg::REG_IMASK);
    endfunction

    logic rem_lvl;
    logic setup;
    logic wr;
    logic cmd_wr;
    logic cmd_on;
    logic cmd_off;
    logic cmd_lset;
    logic cmd_lclr;
    logic trig_fire;
    logic stby_ev;
    logic [3:0] ev;

    // event and command decode
    always_comb begin
        rem_lvl   = rem_q ^ s_r.inv;
        setup     = psel && !penable;
        wr        = psel && penable && s_r.pready && pwrite;
        cmd_wr    = wr && is_reg(paddr, rotp_pkg::REG_CMD);
        cmd_on    = cmd_wr && pwdata[rotp_pkg::CMD_ON];
        cmd_off   = cmd_wr && pwdata[rotp_pkg::CMD_OFF];
        cmd_lset  = cmd_wr && pwdata[rotp_pkg::CMD_LSET];
        cmd_lclr  = cmd_wr && pwdata[rotp_pkg::CMD_LCLR];
        trig_fire = s_r.armed && !trig_q && !s_r.shdn;
        stby_ev   = s_r.stby && s_r.rem_prev && !rem_lvl && !s_r.shdn;
        ev        = 4'h0;
        ev[rotp_pkg::EV_TRIG] = trig_fire;
        ev[rotp_pkg::EV_SHDN] = shd_q && !s_r.shdn;
        ev[rotp_pkg::EV_STBY] = stby_ev;
        ev[rotp_pkg::EV_REM]  = rem_lvl != s_r.rem_prev;
    end

    // next state
    always_comb begin
        s_nxt = s_r;

        // apb: read data captured in setup, writes taken in the zero-wait access phase
        s_nxt.pready  = setup;
        s_nxt.pslverr = setup && !mapped(paddr);
        s_nxt.prdata  = 32'h0000_0000;
        if (setup && !pwrite) begin
            case (paddr)
                rotp_pkg::REG_CTRL: begin
                    s_nxt.prdata[rotp_pkg::CTRL_INV]  = s_r.inv;
                    s_nxt.prdata[rotp_pkg::CTRL_IGN]  = s_r.ign;
                    s_nxt.prdata[rotp_pkg::CTRL_STBY] = s_r.stby;
                end
                rotp_pkg::REG_TRIG: begin
                    s_nxt.prdata[rotp_pkg::CMD_ACT] = s_r.act;
                    s_nxt.prdata[31:16]             = s_r.width;
                end
                rotp_pkg::REG_STATUS: begin
                    s_nxt.prdata[rotp_pkg::ST_OUT]   = s_r.out_en;
                    s_nxt.prdata[rotp_pkg::ST_SWON]  = s_r.sw_on;
                    s_nxt.prdata[rotp_pkg::ST_STBY]  = s_r.standby;
                    s_nxt.prdata[rotp_pkg::ST_SHDN]  = s_r.shdn;
                    s_nxt.prdata[rotp_pkg::ST_LIST]  = s_r.flag != rotp_pkg::FLAG_STATUS;
                    s_nxt.prdata[rotp_pkg::ST_REM]   = rem_lvl;
                    s_nxt.prdata[rotp_pkg::ST_TRIG]  = trig_q;
                    s_nxt.prdata[rotp_pkg::ST_ARMED] = s_r.armed;
                end
                rotp_pkg::REG_IST:   s_nxt.prdata[3:0] = s_r.ist;
                rotp_pkg::REG_IMASK: s_nxt.prdata[3:0] = s_r.imask;
                default:             s_nxt.prdata = 32'h0000_0000;
            endcase
        end

        // control and mask writes
        if (wr && is_reg(paddr, rotp_pkg::REG_CTRL)) begin
            s_nxt.inv  = pwdata[rotp_pkg::CTRL_INV];
            s_nxt.ign  = pwdata[rotp_pkg::CTRL_IGN];
            s_nxt.stby = pwdata[rotp_pkg::CTRL_STBY];
        end
        if (wr && is_reg(paddr, rotp_pkg::REG_IMASK)) begin
            s_nxt.imask = pwdata[3:0];
        end

        // sticky events: a new event wins over a same-cycle clear
        if (wr && is_reg(paddr, rotp_pkg::REG_IST)) begin
            s_nxt.ist = s_r.ist & ~pwdata[3:0];
        end
        s_nxt.ist = s_nxt.ist | ev;
        s_nxt.irq = |(s_nxt.ist & s_nxt.imask);

        // software output state; on clears standby, refused once shut down
        if (cmd_on && !s_r.shdn) begin
            s_nxt.sw_on   = 1'b1;
            s_nxt.standby = 1'b0;
        end
        if (cmd_off) begin
            s_nxt.sw_on = 1'b0;
        end
        // standby after the on command so a same-cycle drop still disables
        if (stby_ev) begin
            s_nxt.sw_on   = 1'b0;
            s_nxt.standby = 1'b1;
        end
        s_nxt.rem_prev = rem_lvl;

        // shutdown latches; only presetn clears it
        if (shd_q) begin
            s_nxt.shdn = 1'b1;
        end

        // output: remote level gates only in plain mode
        s_nxt.out_en = s_nxt.sw_on && !s_nxt.shdn &&
                       (s_r.ign || s_r.stby || rem_lvl);
        s_nxt.ok_flag = !s_nxt.shdn;
        s_nxt.red     = s_nxt.shdn;

        // trigger: one event per low, rearmed by a high
        s_nxt.trig_ev = trig_fire;
        if (trig_fire) begin
            s_nxt.armed = 1'b0;
        end else if (trig_q) begin
            s_nxt.armed = 1'b1;
        end

        // output-off flag: status mirror or trigger pulse output
        case (s_r.flag)
            rotp_pkg::FLAG_STATUS: begin
                s_nxt.off_flag = !s_r.out_en;
            end
            rotp_pkg::FLAG_IDLE: begin
                s_nxt.off_flag = !s_r.act;
                if (trig_fire) begin
                    s_nxt.flag     = rotp_pkg::FLAG_PULSE;
                    s_nxt.off_flag = s_r.act;
                    s_nxt.pcnt     = (s_r.width == 16'h0000) ? 16'h0000
                                                              : s_r.width - 16'h0001;
                end
            end
            rotp_pkg::FLAG_PULSE: begin
                if (s_r.pcnt == 16'h0000) begin
                    s_nxt.flag     = rotp_pkg::FLAG_IDLE;
                    s_nxt.off_flag = !s_r.act;
                end else begin
                    s_nxt.pcnt = s_r.pcnt - 16'h0001;
                end
            end
            default: begin
                s_nxt.flag = rotp_pkg::FLAG_STATUS;
            end
        endcase
        // commands override the flag machine; a pulse in flight is dropped
        if (cmd_lset) begin
            s_nxt.flag     = rotp_pkg::FLAG_IDLE;
            s_nxt.act      = pwdata[rotp_pkg::CMD_ACT];
            s_nxt.width    = pwdata[31:rotp_pkg::CMD_W_LSB];
            s_nxt.off_flag = !pwdata[rotp_pkg::CMD_ACT];
        end
        if (cmd_lclr) begin
            s_nxt.flag = rotp_pkg::FLAG_STATUS;
        end

        // response watch counters, read only by the checks below
        s_nxt.rcnt = (rem_sync != rem_q) ? s_r.rcnt + 23'h000001 : 23'h000000;
        s_nxt.tcnt = (!trig_sync && s_r.armed && !s_r.shdn) ? s_r.tcnt + 14'h0001
                                                            : 14'h0000;
        s_nxt.scnt = (shd_sync && !s_r.shdn) ? s_r.scnt + 12'h001 : 12'h000;
    end

    // state register; shutdown clears only here, flag mode here and on list clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r          <= '0;
            s_r.flag     <= rotp_pkg::FLAG_STATUS;
            s_r.width    <= rotp_pkg::TRIG_W_RST;
            s_r.imask    <= rotp_pkg::IMASK_RST;
            s_r.armed    <= 1'b1;
            s_r.rem_prev <= 1'b1;
            s_r.off_flag <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign prdata             = s_r.prdata;
    assign pready             = s_r.pready;
    assign pslverr            = s_r.pslverr;
    assign output_enable      = s_r.out_en;
    assign trigger_event      = s_r.trig_ev;
    assign power_ok_flag_on   = s_r.ok_flag;
    assign output_off_flag_on = s_r.off_flag;
    assign power_fault_red    = s_r.red;
    assign irq                = s_r.irq;

    a_remote_low_off: assert property (@(posedge pclk) disable iff (!presetn)
        (!s_r.ign && !s_r.stby && !s_r.inv && !rem_q) |=> !s_r.out_en)
        else $error("output on while remote input low");

    a_polarity_inv: assert property (@(posedge pclk) disable iff (!presetn)
        (!s_r.ign && !s_r.stby && s_r.inv && rem_q) |=> !s_r.out_en)
        else $error("inverted remote high did not disable");

    a_ignore_cmd: assert property (@(posedge pclk) disable iff (!presetn)
        (s_r.ign && s_r.sw_on && !s_r.shdn && !shd_q && !stby_ev && !cmd_off)
        |=> s_r.out_en)
        else $error("ignore mode output not following command");

    a_standby_entry: assert property (@(posedge pclk) disable iff (!presetn)
        stby_ev |=> (!s_r.out_en && s_r.standby))
        else $error("standby not entered on qualified low");

    a_standby_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (s_r.standby && !cmd_on) |=> (s_r.standby && !s_r.out_en))
        else $error("standby left without on command");

    a_remote_budget: assert property (@(posedge pclk) disable iff (!presetn)
        32'(s_r.rcnt) < REM_RESP_MAX_CYC)
        else $error("remote input change not taken in time");

    a_trig_once: assert property (@(posedge pclk) disable iff (!presetn)
        s_r.trig_ev |=> (!s_r.trig_ev && !s_r.armed) [*2])
        else $error("second trigger before rearm");

    a_trig_budget: assert property (@(posedge pclk) disable iff (!presetn)
        32'(s_r.tcnt) < TRIG_RESP_MAX_CYC)
        else $error("trigger not answered in time");

    a_shdn_budget: assert property (@(posedge pclk) disable iff (!presetn)
        32'(s_r.scnt) < rotp_pkg::SHDN_MAX_CYC)
        else $error("shutdown not completed in time");

    a_shdn_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        s_r.shdn |=> (s_r.shdn && s_r.red && !s_r.ok_flag && !s_r.out_en))
        else $error("shutdown released or outputs wrong");

    a_flag_status: assert property (@(posedge pclk) disable iff (!presetn)
        (s_r.flag == rotp_pkg::FLAG_STATUS) ##1 (s_r.flag == rotp_pkg::FLAG_STATUS)
        |-> (s_r.off_flag == !$past(s_r.out_en)))
        else $error("off flag does not mirror output");

    a_list_setup: assert property (@(posedge pclk) disable iff (!presetn)
        (cmd_lset && !cmd_lclr) |=> (s_r.flag == rotp_pkg::FLAG_IDLE &&
                                     s_r.off_flag == !s_r.act))
        else $error("list setup did not take the flag");

    a_list_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        (s_r.flag == rotp_pkg::FLAG_IDLE && trig_fire && !cmd_wr)
        |=> (s_r.off_flag == s_r.act) && (s_r.pcnt == $past(s_r.width) - 16'h0001
                                          || $past(s_r.width) == 16'h0000))
        else $error("trigger pulse level or width wrong");

    a_list_clear: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_lclr |=> s_r.flag == rotp_pkg::FLAG_STATUS)
        else $error("list clear did not restore flag");
endmodule

// *** hdl/rotp_pkg.sv ***
// rotp_pkg: constants, register map and types for the remote i/o control block
// assumes a 25 MHz pclk; all offsets are byte addresses on a 32-bit APB
package rotp_pkg;
    // clock rate and documented times
    localparam int unsigned CLK_KHZ          = 25000;
    localparam int unsigned QUAL_US          = 100;   // least low hold on remote and trigger inputs
    localparam int unsigned SHDN_MAX_US      = 100;   // longest shutdown response
    localparam int unsigned TRIG_RESP_MAX_US = 500;   // longest trigger response
    localparam int unsigned REM_RESP_MAX_MS  = 200;   // longest remote on/off response

    // derived cycle counts (least time rounds up, longest rounds down)
    localparam logic [11:0] QUAL_CYC      = 12'((QUAL_US * CLK_KHZ + 999) / 1000);
    localparam int unsigned SHDN_MAX_CYC  = SHDN_MAX_US * CLK_KHZ / 1000;
    localparam logic [11:0] SHDN_FILT_CYC = 12'h004;  // short glitch filter on shutdown

    // register byte offsets
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_CMD    = 8'h04;
    localparam logic [7:0] REG_TRIG   = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [7:0] REG_IST    = 8'h10;
    localparam logic [7:0] REG_IMASK  = 8'h14;

    // control register fields
    localparam int unsigned CTRL_INV  = 0;
    localparam int unsigned CTRL_IGN  = 1;
    localparam int unsigned CTRL_STBY = 2;

    // command register fields (write only)
    localparam int unsigned CMD_ON    = 0;
    localparam int unsigned CMD_OFF   = 1;
    localparam int unsigned CMD_LSET  = 2;
    localparam int unsigned CMD_LCLR  = 3;
    localparam int unsigned CMD_ACT   = 8;
    localparam int unsigned CMD_W_LSB = 16;

    // status register fields
    localparam int unsigned ST_OUT   = 0;
    localparam int unsigned ST_SWON  = 1;
    localparam int unsigned ST_STBY  = 2;
    localparam int unsigned ST_SHDN  = 3;
    localparam int unsigned ST_LIST  = 4;
    localparam int unsigned ST_REM   = 5;
    localparam int unsigned ST_TRIG  = 6;
    localparam int unsigned ST_ARMED = 7;

    // interrupt event bits
    localparam int unsigned EV_TRIG = 0;
    localparam int unsigned EV_SHDN = 1;
    localparam int unsigned EV_STBY = 2;
    localparam int unsigned EV_REM  = 3;

    // values after reset
    localparam logic [15:0] TRIG_W_RST = 16'h0001;
    localparam logic [3:0]  IMASK_RST  = 4'h0;

    // output-off flag use
    typedef enum logic [2:0] {
        FLAG_STATUS = 3'b001,
        FLAG_IDLE   = 3'b010,
        FLAG_PULSE  = 3'b100
    } rotp_flag_t;
endpackage

// *** hdl/rotp_qual.sv ***
// rotp_qual: two-flop synchroniser and level qualifier for one discrete pin
// assumes the pin is asynchronous to pclk; level follows after n steady cycles
`timescale 1ns/1ps
module rotp_qual #(
    parameter logic [11:0] N    = 12'h004,
    parameter logic        INIT = 1'b1
) (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // pin side
    input  wire logic pin,
    // qualified side
    output logic      sync,
    output logic      level
);
    typedef struct packed {
        logic        s1;
        logic        s2;
        logic        lvl;
        logic [11:0] cnt;
    } rotp_qual_st_t;

    rotp_qual_st_t s_r;
    rotp_qual_st_t s_nxt;

    // a new level is taken only after it stood n cycles, so short pulses vanish
    always_comb begin
        s_nxt    = s_r;
        s_nxt.s1 = pin;
        s_nxt.s2 = s_r.s1;
        if (s_r.s2 == s_r.lvl) begin
            s_nxt.cnt = 12'h000;
        end else if (s_r.cnt >= N - 12'h001) begin
            s_nxt.lvl = s_r.s2;
            s_nxt.cnt = 12'h000;
        end else begin
            s_nxt.cnt = s_r.cnt + 12'h001;
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '{s1: INIT, s2: INIT, lvl: INIT, cnt: 12'h000};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign sync  = s_r.s2;
    assign level = s_r.lvl;
endmodule

// *** test/rotp_ext_model.sv ***
// rotp_ext_model: external equipment that drives the three discrete pins
// assumes the bench calls its tasks; open pins read high, shutdown led dark
`timescale 1ns/1ps
module rotp_ext_model (
    // clock
    input  wire logic pclk,
    // driven pins
    output logic      remote_onoff_in,
    output logic      ext_trigger_in,
    output logic      ext_shutdown_in
);
    // pins start open, shutdown led unpowered
    initial begin
        remote_onoff_in = 1'b1;
        ext_trigger_in  = 1'b1;
        ext_shutdown_in = 1'b0;
    end

    // hold trigger low n cycles, then release to open so it rearms
    task automatic trig(input int n);
        @(posedge pclk) ext_trigger_in <= 1'b0;
        repeat (n) @(posedge pclk);
        ext_trigger_in <= 1'b1;
    endtask

    // remote level; a high after standby is not enough, the bench must command on
    task automatic remote(input logic v);
        @(posedge pclk) remote_onoff_in <= v;
    endtask

    task automatic shut(input logic v);
        @(posedge pclk) ext_shutdown_in <= v;
    endtask
endmodule

// *** test/remote_output_trigger_protect_io_tb.sv ***
// remote_output_trigger_protect_io_tb: self-checking bench for rotp_top
// assumes rotp_ext_model drives the pins and this module is the apb master
`timescale 1ns/1ps
module remote_output_trigger_protect_io_tb;
    typedef struct packed {
        logic w; logic [7:0] a; logic [31:0] d; logic [31:0] q; logic e;
    } rotp_row_t;
    logic        pclk, presetn, psel, penable, pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic        pready, pslverr, e, rem, trg, sdn;
    logic        oe, tev, pok, offf, red, irq;
    int          n_errors = 0;
    int          tests_run = 0;
    int          n_trig = 0;
    int          n_low = 0;
    int          base;
    // register rows: direction, address, write data, read data, error
    rotp_row_t   rows [10] = '{
        '{1'b1, rotp_pkg::REG_CTRL, 32'h0000_0007, 32'h0, 1'b0},
        '{1'b0, rotp_pkg::REG_CTRL, 32'h0, 32'h0000_0007, 1'b0},
        '{1'b1, rotp_pkg::REG_CTRL, 32'h0, 32'h0, 1'b0},
        '{1'b0, rotp_pkg::REG_TRIG, 32'h0, 32'h0001_0000, 1'b0},
        '{1'b0, rotp_pkg::REG_CMD, 32'h0, 32'h0, 1'b0},
        '{1'b1, rotp_pkg::REG_IMASK, 32'h0000_000F, 32'h0, 1'b0},
        '{1'b0, rotp_pkg::REG_IMASK, 32'h0, 32'h0000_000F, 1'b0},
        '{1'b1, rotp_pkg::REG_IMASK, 32'h0, 32'h0, 1'b0},
        '{1'b0, 8'h18, 32'h0, 32'h0, 1'b1},
        '{1'b1, 8'h1C, 32'hFFFF_FFFF, 32'h0, 1'b1}};

    rotp_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .remote_onoff_in(rem), .ext_trigger_in(trg),
        .ext_shutdown_in(sdn), .output_enable(oe), .trigger_event(tev),
        .power_ok_flag_on(pok), .output_off_flag_on(offf), .power_fault_red(red), .irq(irq));
    rotp_ext_model u_ext (.pclk(pclk), .remote_onoff_in(rem), .ext_trigger_in(trg),
        .ext_shutdown_in(sdn));

    // 25 MHz clock
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // count trigger pulses and cycles with the off flag not conducting
    always @(posedge pclk) begin
        if (tev === 1'b1) n_trig <= n_trig + 1;
        if (offf === 1'b0) n_low <= n_low + 1;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one apb transfer; the request is held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic er);
        int k;
        k = 0;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && ++k < 50);
        if (k >= 50) begin
            n_errors++;
            print_verdict();
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, q, e);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic print_verdict();
        if (n_errors == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // watchdog: the whole sequence needs about 35k cycles
    initial begin
        cyc(60000);
        n_errors++;
        print_verdict();
    end

    // main sequence
    initial begin
        presetn = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0;
        cyc(16);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d, q, e);
            if (!rows[i].w) chk(q, rows[i].q);
            chk({31'h0, e}, {31'h0, rows[i].e});
        end
        chk({31'h0, offf}, 32'h1);
        wr(rotp_pkg::REG_CMD, 32'h0000_0001);
        cyc(3);
        chk({31'h0, oe}, 32'h1);
        chk({31'h0, offf}, 32'h0);
        chk({31'h0, pok}, 32'h1);
        // a low shorter than the qualify time must be ignored
        u_ext.remote(1'b0);
        cyc(100);
        u_ext.remote(1'b1);
        cyc(2600);
        chk({31'h0, oe}, 32'h1);
        u_ext.remote(1'b0);
        cyc(2600);
        chk({31'h0, oe}, 32'h0);
        chk({31'h0, irq}, 32'h0);
        wr(rotp_pkg::REG_IMASK, 32'h0000_0008);
        cyc(2);
        chk({31'h0, irq}, 32'h1);
        wr(rotp_pkg::REG_IST, 32'h0000_0008);
        cyc(2);
        chk({31'h0, irq}, 32'h0);
        wr(rotp_pkg::REG_CTRL, 32'h0000_0001);
        cyc(5);
        chk({31'h0, oe}, 32'h1);
        wr(rotp_pkg::REG_CTRL, 32'h0000_0002);
        wr(rotp_pkg::REG_CMD, 32'h0000_0002);
        cyc(3);
        chk({31'h0, oe}, 32'h0);
        wr(rotp_pkg::REG_CMD, 32'h0000_0001);
        cyc(3);
        chk({31'h0, oe}, 32'h1);
        // standby: fall disables, rise alone does not restore
        u_ext.remote(1'b1);
        cyc(2600);
        wr(rotp_pkg::REG_CTRL, 32'h0000_0004);
        u_ext.remote(1'b0);
        cyc(2600);
        chk({31'h0, oe}, 32'h0);
        u_ext.remote(1'b1);
        cyc(2600);
        chk({31'h0, oe}, 32'h0);
        wr(rotp_pkg::REG_CMD, 32'h0000_0001);
        cyc(3);
        chk({31'h0, oe}, 32'h1);
        // trigger: one event, short pulse ignored, long hold gives one only
        u_ext.trig(2600);
        chk(n_trig, 32'h1);
        cyc(2600);
        u_ext.trig(100);
        cyc(2600);
        chk(n_trig, 32'h1);
        u_ext.trig(6000);
        cyc(2600);
        chk(n_trig, 32'h2);
        // list mode: active level 0, width 5
        wr(rotp_pkg::REG_CMD, 32'h0005_0004);
        cyc(3);
        chk({31'h0, offf}, 32'h1);
        apb(1'b0, rotp_pkg::REG_TRIG, 32'h0, q, e);
        chk(q, 32'h0005_0000);
        base = n_low;
        u_ext.trig(2600);
        cyc(2600);
        chk(n_low - base, 32'h5);
        wr(rotp_pkg::REG_CMD, 32'h0000_0008);
        cyc(3);
        chk({31'h0, offf}, 32'h0);
        // shutdown latches until reset
        wr(rotp_pkg::REG_IMASK, 32'h0000_0002);
        u_ext.shut(1'b1);
        cyc(20);
        chk({31'h0, oe}, 32'h0);
        chk({31'h0, red}, 32'h1);
        chk({31'h0, pok}, 32'h0);
        chk({31'h0, irq}, 32'h1);
        u_ext.shut(1'b0);
        wr(rotp_pkg::REG_CMD, 32'h0000_0001);
        cyc(20);
        chk({31'h0, oe}, 32'h0);
        chk({31'h0, red}, 32'h1);
        presetn <= 1'b0;
        cyc(2);
        presetn <= 1'b1;
        cyc(3);
        chk({31'h0, red}, 32'h0);
        chk({31'h0, pok}, 32'h1);
        print_verdict();
    end
endmodule
